// >>> include/rmcd_pkg.sv
`default_nettype none
package rmcd_pkg;

  // Command codes.
  localparam logic [7:0] CMD_RAW_S0  = 8'ha0;
  localparam logic [7:0] CMD_RAW_S1  = 8'ha1;
  localparam logic [7:0] CMD_RAW_S2  = 8'ha2;
  localparam logic [7:0] CMD_RAW_S3  = 8'ha3;
  localparam logic [7:0] CMD_RAW_T   = 8'ha6;
  localparam logic [7:0] CMD_FULL    = 8'haa;
  localparam logic [7:0] CMD_SEL_PRI = 8'hb0;
  localparam logic [7:0] CMD_SEL_SEC = 8'hb1;

  // Measurement configuration word and written bytes needed for an inline one.
  localparam int         CFG_W      = 16;
  localparam logic [3:0] INLINE_MIN = 4'h3;
  localparam logic [3:0] WCNT_MAX   = 4'hf;

  // Read lengths in bytes and the read index ceiling.
  localparam logic [3:0] LEN_RAW   = 4'h4;
  localparam logic [3:0] LEN_OTHER = 4'h5;
  localparam logic [3:0] LEN_FULL  = 4'h8;
  localparam logic [3:0] IDX_MAX   = 4'h8;

  // Status byte fields.
  localparam logic [7:0] ST_SEL_MASK   = 8'h02;
  localparam logic [7:0] ST_BUSY_MASK  = 8'h20;
  localparam logic [7:0] ST_POWER_MASK = 8'h40;

  // Values after reset.
  localparam logic       SEL_RST = 1'b0;
  localparam logic [3:0] CNT_RST = 4'h0;

  // Bit count of one I2C byte.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BIT_OUT = 4'h1;

  typedef enum logic [1:0] {
    RMCD_RES_NONE,
    RMCD_RES_SENSOR,
    RMCD_RES_TEMP,
    RMCD_RES_FULL
  } rmcd_res_t;

  typedef enum logic [2:0] {
    RMCD_ST_IDLE,
    RMCD_ST_ADDR,
    RMCD_ST_RX,
    RMCD_ST_ACK,
    RMCD_ST_TX,
    RMCD_ST_MACK
  } rmcd_i2c_st_t;

  function automatic logic [3:0] rmcd_rd_len(input rmcd_res_t res);
    rmcd_rd_len = (res == RMCD_RES_FULL) ? LEN_FULL :
                  (res == RMCD_RES_NONE) ? LEN_OTHER : LEN_RAW;
  endfunction

endpackage
`default_nettype wire

// >>> include/rmcd_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rmcd_byte_if;
  logic       frame_begin;
  logic       frame_rw;
  logic       frame_end;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_take;
  logic [7:0] tx_data;

  modport slave (
    output frame_begin,
    output frame_rw,
    output frame_end,
    output rx_valid,
    output rx_data,
    output tx_take,
    input  tx_data
  );

  modport decoder (
    input  frame_begin,
    input  frame_rw,
    input  frame_end,
    input  rx_valid,
    input  rx_data,
    input  tx_take,
    output tx_data
  );
endinterface
`default_nettype wire

// >>> hdl/rmcd_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module rmcd_i2c_slave (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Bus pins.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Own address.
  input  wire logic [6:0] dev_addr,
  // Byte side.
  rmcd_byte_if.slave      bif
);

  rmcd_pkg::rmcd_i2c_st_t state_reg;
  logic       scl_reg;
  logic       sda_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic       rw_reg;
  logic       nack_reg;
  logic       oe_reg;
  logic       active_reg;
  logic       begin_reg;
  logic       rxv_reg;
  logic       end_reg;
  logic       take_reg;

  wire scl_rise   = scl_in & ~scl_reg;
  wire scl_fall   = ~scl_in & scl_reg;
  wire start_cond = scl_in & scl_reg & sda_reg & ~sda_in;
  wire stop_cond  = scl_in & scl_reg & ~sda_reg & sda_in;
  wire byte_done  = (cnt_reg == rmcd_pkg::BITS_PER_BYTE);
  wire addr_hit   = (sh_reg[7:1] == dev_addr);
  wire load_tx    = scl_fall & (((state_reg == rmcd_pkg::RMCD_ST_ACK) & rw_reg) |
                                ((state_reg == rmcd_pkg::RMCD_ST_MACK) & ~nack_reg));

  assign sda_out         = 1'b0;
  assign sda_oe          = oe_reg;
  assign bif.frame_begin = begin_reg;
  assign bif.frame_rw    = rw_reg;
  assign bif.frame_end   = end_reg;
  assign bif.rx_valid    = rxv_reg;
  assign bif.rx_data     = sh_reg;
  assign bif.tx_take     = take_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  // Open-drain slave: START, address with acknowledge, data with acknowledge, STOP.
  always_ff @(posedge core_clk) begin
    begin_reg <= 1'b0;
    rxv_reg   <= 1'b0;
    end_reg   <= 1'b0;
    take_reg  <= 1'b0;
    if (rst) begin
      state_reg  <= rmcd_pkg::RMCD_ST_IDLE;
      cnt_reg    <= rmcd_pkg::CNT_RST;
      sh_reg     <= 8'h00;
      rw_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      oe_reg     <= 1'b0;
      active_reg <= 1'b0;
    end else if (start_cond || stop_cond) begin
      state_reg  <= start_cond ? rmcd_pkg::RMCD_ST_ADDR : rmcd_pkg::RMCD_ST_IDLE;
      cnt_reg    <= rmcd_pkg::CNT_RST;
      oe_reg     <= 1'b0;
      end_reg    <= active_reg;
      active_reg <= 1'b0;
    end else if (load_tx) begin
      sh_reg    <= bif.tx_data;
      oe_reg    <= ~bif.tx_data[7];
      take_reg  <= 1'b1;
      cnt_reg   <= rmcd_pkg::FIRST_BIT_OUT;
      state_reg <= rmcd_pkg::RMCD_ST_TX;
    end else begin
      unique case (state_reg)
        rmcd_pkg::RMCD_ST_IDLE: begin
        end
        rmcd_pkg::RMCD_ST_ADDR, rmcd_pkg::RMCD_ST_RX: begin
          if (scl_rise && !byte_done) begin
            sh_reg  <= {sh_reg[6:0], sda_in};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (state_reg == rmcd_pkg::RMCD_ST_RX) begin
              rxv_reg   <= 1'b1;
              oe_reg    <= 1'b1;
              state_reg <= rmcd_pkg::RMCD_ST_ACK;
            end else if (addr_hit) begin
              rw_reg     <= sh_reg[0];
              begin_reg  <= 1'b1;
              active_reg <= 1'b1;
              oe_reg     <= 1'b1;
              state_reg  <= rmcd_pkg::RMCD_ST_ACK;
            end else begin
              state_reg <= rmcd_pkg::RMCD_ST_IDLE;
            end
          end
        end
        rmcd_pkg::RMCD_ST_ACK: begin
          if (scl_fall) begin
            oe_reg    <= 1'b0;
            cnt_reg   <= rmcd_pkg::CNT_RST;
            state_reg <= rmcd_pkg::RMCD_ST_RX;
          end
        end
        rmcd_pkg::RMCD_ST_TX: begin
          if (scl_fall && byte_done) begin
            oe_reg    <= 1'b0;
            state_reg <= rmcd_pkg::RMCD_ST_MACK;
          end else if (scl_fall) begin
            oe_reg  <= ~sh_reg[6];
            sh_reg  <= {sh_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        rmcd_pkg::RMCD_ST_MACK: begin
          if (scl_rise) begin
            nack_reg <= sda_in;
          end else if (scl_fall) begin
            state_reg <= rmcd_pkg::RMCD_ST_IDLE;
          end
        end
        default: begin
          state_reg <= rmcd_pkg::RMCD_ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> hdl/rmcd_decoder.sv
// What this block does
// - Commands A0 and A2 measure with the stored configuration that is currently selected.
// - Commands A1 and A3 measure with a configuration sent over the bus instead of a stored one.
// - For A3 the two bytes right after the command byte form the configuration used for that measurement.
// - The raw temperature command A6 uses the stored configuration and ignores any bytes after the command.
// - Until a selection command arrives after reset, the primary configuration is the selected one.
// - A selection holds until reset or a command that selects the other configuration.
// - A read returns 4, 5 or 8 bytes depending on the last command.
// - A read starts with the status byte and then gives the result bytes, or the selected stored configuration after reset or a selection command.
// - The block acts as a plain I2C slave with START, address, acknowledge and STOP framing.
// - Bit 1 of the status byte shows which stored configuration is selected.
// - Command B0 selects the primary configuration and command B1 the secondary one.
`timescale 1ns/1ps
`default_nettype none
module rmcd_decoder (
  // Clock and reset.
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Serial bus pins and own address.
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  input  wire logic [6:0]                 dev_addr,
  // Stored measurement configurations.
  input  wire logic [rmcd_pkg::CFG_W-1:0] meas_cfg_primary,
  input  wire logic [rmcd_pkg::CFG_W-1:0] meas_cfg_secondary,
  // Measurement engine.
  output logic                            meas_start,
  output logic                            meas_temp,
  output logic                            meas_full,
  output logic [rmcd_pkg::CFG_W-1:0]      meas_cfg_applied,
  input  wire logic                       meas_done,
  input  wire logic [23:0]                meas_sensor_val,
  input  wire logic [23:0]                meas_temp_val,
  // State.
  output logic                            cfg_sel_secondary,
  output logic                            busy
);

  rmcd_byte_if bif ();

  rmcd_i2c_slave u_slave (
    .core_clk (core_clk),
    .rst      (rst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .dev_addr (dev_addr),
    .bif      (bif)
  );

  rmcd_pkg::rmcd_res_t            res_reg;
  logic [7:0]                     cmd_reg;
  logic [7:0]                     d1_reg;
  logic [7:0]                     d2_reg;
  logic [3:0]                     wcnt_reg;
  logic [3:0]                     idx_reg;
  logic                           wr_frame_reg;
  logic                           sel_reg;
  logic                           busy_reg;
  logic                           start_reg;
  logic                           temp_reg;
  logic                           full_reg;
  logic [rmcd_pkg::CFG_W-1:0]     cfg_reg;
  logic [23:0]                    sens_reg;
  logic [23:0]                    tres_reg;

  // Command decode.
  wire exec       = bif.frame_end & wr_frame_reg & (wcnt_reg != rmcd_pkg::CNT_RST);
  wire is_stored  = (cmd_reg == rmcd_pkg::CMD_RAW_S0) | (cmd_reg == rmcd_pkg::CMD_RAW_S2) |
                    (cmd_reg == rmcd_pkg::CMD_RAW_T) | (cmd_reg == rmcd_pkg::CMD_FULL);
  wire is_inline  = (cmd_reg == rmcd_pkg::CMD_RAW_S1) | (cmd_reg == rmcd_pkg::CMD_RAW_S3);
  wire inline_ok  = is_inline & (wcnt_reg >= rmcd_pkg::INLINE_MIN);
  wire go         = exec & (is_stored | inline_ok) & ~busy_reg;
  wire sel_pri    = exec & (cmd_reg == rmcd_pkg::CMD_SEL_PRI);
  wire sel_sec    = exec & (cmd_reg == rmcd_pkg::CMD_SEL_SEC);

  // Configuration choice.
  wire [rmcd_pkg::CFG_W-1:0] stored_cfg = sel_reg ? meas_cfg_secondary : meas_cfg_primary;
  wire [rmcd_pkg::CFG_W-1:0] cfg_next   = is_inline ? {d1_reg, d2_reg} : stored_cfg;
  wire rmcd_pkg::rmcd_res_t  res_next   = (cmd_reg == rmcd_pkg::CMD_RAW_T) ? rmcd_pkg::RMCD_RES_TEMP :
                                          (cmd_reg == rmcd_pkg::CMD_FULL) ? rmcd_pkg::RMCD_RES_FULL :
                                          rmcd_pkg::RMCD_RES_SENSOR;

  // Read data.
  wire [7:0]  status_byte = rmcd_pkg::ST_POWER_MASK |
                            (busy_reg ? rmcd_pkg::ST_BUSY_MASK : 8'h00) |
                            (sel_reg ? rmcd_pkg::ST_SEL_MASK : 8'h00);
  wire [63:0] rd_frame    = (res_reg == rmcd_pkg::RMCD_RES_FULL)   ? {status_byte, sens_reg, tres_reg, 8'h00} :
                            (res_reg == rmcd_pkg::RMCD_RES_SENSOR) ? {status_byte, sens_reg, 32'h0} :
                            (res_reg == rmcd_pkg::RMCD_RES_TEMP)   ? {status_byte, tres_reg, 32'h0} :
                            {status_byte, stored_cfg, 40'h0};
  wire [63:0] rd_shift    = rd_frame << {idx_reg, 3'b000};
  wire [3:0]  rd_len      = rmcd_pkg::rmcd_rd_len(res_reg);
  wire        in_len      = (idx_reg < rd_len);

  assign bif.tx_data       = in_len ? rd_shift[63:56] : 8'h00;
  assign meas_start        = start_reg;
  assign meas_temp         = temp_reg;
  assign meas_full         = full_reg;
  assign meas_cfg_applied  = cfg_reg;
  assign cfg_sel_secondary = sel_reg;
  assign busy              = busy_reg;

  // Write frame capture; bytes past the second data byte are ignored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_frame_reg <= 1'b0;
      wcnt_reg     <= rmcd_pkg::CNT_RST;
      cmd_reg      <= 8'h00;
      d1_reg       <= 8'h00;
      d2_reg       <= 8'h00;
    end else if (bif.frame_begin) begin
      wr_frame_reg <= ~bif.frame_rw;
      if (!bif.frame_rw) begin
        wcnt_reg <= rmcd_pkg::CNT_RST;
      end
    end else if (bif.rx_valid) begin
      if (wcnt_reg == 4'h0) begin
        cmd_reg <= bif.rx_data;
      end
      if (wcnt_reg == 4'h1) begin
        d1_reg <= bif.rx_data;
      end
      if (wcnt_reg == 4'h2) begin
        d2_reg <= bif.rx_data;
      end
      if (wcnt_reg != rmcd_pkg::WCNT_MAX) begin
        wcnt_reg <= wcnt_reg + 4'h1;
      end
    end
  end

  // Read index: restarts at the status byte on every read frame.
  always_ff @(posedge core_clk) begin
    if (rst || (bif.frame_begin && bif.frame_rw)) begin
      idx_reg <= rmcd_pkg::CNT_RST;
    end else if (bif.tx_take && idx_reg != rmcd_pkg::IDX_MAX) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  // Selection state.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_reg <= rmcd_pkg::SEL_RST;
    end else if (sel_sec) begin
      sel_reg <= 1'b1;
    end else if (sel_pri) begin
      sel_reg <= 1'b0;
    end
  end

  // Measurement launch; a measurement command arriving while busy is dropped.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
      temp_reg  <= 1'b0;
      full_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      cfg_reg   <= '0;
      res_reg   <= rmcd_pkg::RMCD_RES_NONE;
    end else begin
      start_reg <= go;
      if (go) begin
        busy_reg <= 1'b1;
        cfg_reg  <= cfg_next;
        temp_reg <= (cmd_reg == rmcd_pkg::CMD_RAW_T);
        full_reg <= (cmd_reg == rmcd_pkg::CMD_FULL);
        res_reg  <= res_next;
      end else begin
        if (meas_done) begin
          busy_reg <= 1'b0;
        end
        if (sel_pri || sel_sec) begin
          res_reg <= rmcd_pkg::RMCD_RES_NONE;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sens_reg <= 24'h000000;
      tres_reg <= 24'h000000;
    end else if (meas_done && busy_reg) begin
      sens_reg <= meas_sensor_val;
      tres_reg <= meas_temp_val;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_stored_cfg_use: assert property (go && is_stored |=> meas_start && meas_cfg_applied == $past(stored_cfg))
    else $error("stored measurement used the wrong configuration");
  chk_inline_cfg_use: assert property (go && is_inline |=> meas_cfg_applied == {$past(d1_reg), $past(d2_reg)})
    else $error("inline measurement did not apply the sent bytes");
  chk_short_inline_drop: assert property (exec && is_inline && !inline_ok |=> !meas_start)
    else $error("inline command without configuration bytes started a measurement");
  chk_sel_after_reset: assert property (disable iff (1'b0) rst |=> !cfg_sel_secondary)
    else $error("selection not primary after reset");
  chk_sel_holds: assert property (!sel_pri && !sel_sec |=> $stable(cfg_sel_secondary))
    else $error("selection changed without a selection command");
  chk_sel_commands: assert property (sel_sec |=> cfg_sel_secondary ##1 (sel_pri || cfg_sel_secondary))
    else $error("secondary selection not taken or lost");
  chk_sel_primary: assert property (sel_pri && !sel_sec |=> !cfg_sel_secondary)
    else $error("primary selection not taken");
  chk_status_first: assert property (bif.frame_begin && bif.frame_rw |=> bif.tx_data == status_byte)
    else $error("read did not open with the status byte");
  chk_status_sel_bit: assert property (bif.tx_take && idx_reg == rmcd_pkg::CNT_RST |->
                                       bif.rx_data[1] == $past(cfg_sel_secondary))
    else $error("status bit 1 does not show the selection");
  chk_read_length: assert property (rd_len == 4'h4 || rd_len == 4'h5 || rd_len == 4'h8)
    else $error("read length outside 4, 5 or 8");
  chk_tail_zero: assert property (idx_reg >= rd_len |-> bif.tx_data == 8'h00)
    else $error("byte past the read length is not zero");
  chk_start_pulse: assert property (meas_start |=> !meas_start && busy)
    else $error("measurement start not a single pulse");

  cov_secondary_meas: cover property (cfg_sel_secondary && go && is_stored);
  cov_inline_meas: cover property (go && cmd_reg == rmcd_pkg::CMD_RAW_S3);
  cov_temp_read: cover property (res_reg == rmcd_pkg::RMCD_RES_TEMP && bif.tx_take && idx_reg == 4'h3);
  cov_full_read: cover property (res_reg == rmcd_pkg::RMCD_RES_FULL && bif.tx_take && idx_reg == 4'h7);

endmodule
`default_nettype wire

// >>> testbench/rmcd_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module rmcd_i2c_master (
  // Clock.
  input  wire logic core_clk,
  // Bus pins.
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_drv
);
  logic sda_line;

  // The line is open drain with a pull-up, so a released line reads high.
  assign sda_line = sda_oe ? 1'b0 : sda_drv;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // SDA only moves while SCL is low; each SCL phase lasts four core clocks.
  task automatic clock_bit(input logic d, output logic q);
    scl <= 1'b0;
    repeat (2) @(posedge core_clk);
    sda_drv <= d;
    repeat (2) @(posedge core_clk);
    scl <= 1'b1;
    repeat (2) @(posedge core_clk);
    q = sda_line;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic start_cond();
    scl <= 1'b0;
    repeat (2) @(posedge core_clk);
    sda_drv <= 1'b1;
    repeat (2) @(posedge core_clk);
    scl <= 1'b1;
    repeat (2) @(posedge core_clk);
    sda_drv <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic stop_cond();
    scl <= 1'b0;
    repeat (2) @(posedge core_clk);
    sda_drv <= 1'b0;
    repeat (2) @(posedge core_clk);
    scl <= 1'b1;
    repeat (2) @(posedge core_clk);
    sda_drv <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], q);
    clock_bit(1'b1, q);
    ack = ~q;
  endtask

  task automatic read_byte(output logic [7:0] b, input logic more);
    logic q;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(~more, q);
  endtask
endmodule
`default_nettype wire

// >>> testbench/rmcd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module rmcd_decoder_test;
  localparam logic [6:0]  ADDR = 7'h28;
  localparam logic [15:0] PRI  = 16'h1c35;
  localparam logic [15:0] SEC  = 16'h5a93;
  localparam logic [23:0] SENS = 24'h8c87c0;
  localparam logic [23:0] TMP  = 24'hcb1b80;

  logic        core_clk = 1'b0;
  logic        rst;
  logic        scl_in;
  logic        sda_in;
  logic        sda_drv;
  logic        sda_oe;
  logic        sda_out;
  logic        meas_start;
  logic        meas_temp;
  logic        meas_full;
  logic        meas_done = 1'b0;
  logic [15:0] meas_cfg_applied;
  logic        cfg_sel_secondary;
  logic        busy;
  logic [15:0] seen_cfg = 16'h0000;
  logic        seen_temp = 1'b0;
  logic        seen_full = 1'b0;
  logic [3:0]  eng_cnt = 4'h0;
  int          n_starts = 0;
  int          n_errors = 0;
  int          checks_done = 0;

  always #4 core_clk = ~core_clk;

  assign sda_in = sda_oe ? 1'b0 : sda_drv;

  rmcd_i2c_master i_master (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl_in), .sda_drv(sda_drv));

  rmcd_decoder i_dut (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_addr(ADDR), .meas_cfg_primary(PRI), .meas_cfg_secondary(SEC), .meas_start(meas_start),
    .meas_temp(meas_temp), .meas_full(meas_full), .meas_cfg_applied(meas_cfg_applied),
    .meas_done(meas_done), .meas_sensor_val(SENS), .meas_temp_val(TMP),
    .cfg_sel_secondary(cfg_sel_secondary), .busy(busy)
  );

  // Measurement engine: records what each start asked for, answers five cycles later.
  always @(posedge core_clk) begin
    meas_done <= 1'b0;
    if (meas_start === 1'b1) begin
      n_starts <= n_starts + 1;
      seen_cfg <= meas_cfg_applied;
      seen_temp <= meas_temp;
      seen_full <= meas_full;
      eng_cnt <= 4'h5;
    end else if (eng_cnt != 4'h0) begin
      eng_cnt <= eng_cnt - 4'h1;
      meas_done <= (eng_cnt == 4'h1);
    end
  end

  task automatic print_verdict();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up(input string what);
    n_errors++;
    $display("Error %s expected completion seen timeout", what);
    print_verdict();
  endtask

  function automatic logic [7:0] stat(input logic s);
    return rmcd_pkg::ST_POWER_MASK | (s ? rmcd_pkg::ST_SEL_MASK : 8'h00);
  endfunction

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d1, input logic [7:0] d2, input int nd);
    logic a;
    i_master.start_cond();
    i_master.write_byte({ADDR, 1'b0}, a);
    check("write addr ack", 16'(a), 16'h0001);
    i_master.write_byte(cmd, a);
    check("command ack", 16'(a), 16'h0001);
    if (nd > 0) i_master.write_byte(d1, a);
    if (nd > 1) i_master.write_byte(d2, a);
    i_master.stop_cond();
  endtask

  task automatic measure(input logic [7:0] cmd, input logic [7:0] d1, input logic [7:0] d2, input int nd,
                         input logic [15:0] cfg, input logic t);
    int k0;
    int i;
    k0 = n_starts;
    wr(cmd, d1, d2, nd);
    for (i = 0; i < 40 && n_starts == k0; i++) @(posedge core_clk);
    if (n_starts == k0) give_up("measurement start");
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge core_clk);
    if (busy !== 1'b0) give_up("busy release");
    check("applied config", seen_cfg, cfg);
    check("temperature kind", 16'(seen_temp), 16'(t));
  endtask

  task automatic rd_check(input int n, input logic [7:0] e[8]);
    logic [7:0] got[8];
    logic a;
    i_master.start_cond();
    i_master.write_byte({ADDR, 1'b1}, a);
    check("read addr ack", 16'(a), 16'h0001);
    for (int i = 0; i < n; i++) i_master.read_byte(got[i], i < n - 1);
    i_master.stop_cond();
    for (int i = 0; i < n; i++) check("read byte", 16'(got[i]), 16'(e[i]));
  endtask

  task automatic select(input logic [7:0] cmd, input logic s);
    int i;
    wr(cmd, 8'h00, 8'h00, 0);
    for (i = 0; i < 20 && cfg_sel_secondary !== s; i++) @(posedge core_clk);
    check("selection", 16'(cfg_sel_secondary), 16'(s));
  endtask

  task automatic scn_reset_state();
    check("selection after reset", 16'(cfg_sel_secondary), 16'h0000);
    rd_check(5, '{stat(1'b0), PRI[15:8], PRI[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
  endtask

  task automatic scn_stored_and_inline();
    measure(rmcd_pkg::CMD_RAW_S0, 8'h00, 8'h00, 0, PRI, 1'b0);
    measure(rmcd_pkg::CMD_RAW_S2, 8'h77, 8'h66, 2, PRI, 1'b0);
    rd_check(4, '{stat(1'b0), SENS[23:16], SENS[15:8], SENS[7:0], 8'h00, 8'h00, 8'h00, 8'h00});
    measure(rmcd_pkg::CMD_RAW_S3, 8'h0b, 8'h26, 2, 16'h0b26, 1'b0);
    measure(rmcd_pkg::CMD_RAW_S1, 8'h12, 8'h34, 2, 16'h1234, 1'b0);
    rd_check(4, '{stat(1'b0), SENS[23:16], SENS[15:8], SENS[7:0], 8'h00, 8'h00, 8'h00, 8'h00});
  endtask

  // An inline command with only one configuration byte must not start and must leave the read kind alone.
  task automatic scn_refused();
    int k0;
    k0 = n_starts;
    wr(rmcd_pkg::CMD_RAW_S1, 8'h12, 8'h34, 1);
    repeat (40) @(posedge core_clk);
    check("short inline starts", 16'(n_starts - k0), 16'h0000);
    rd_check(5, '{stat(1'b0), SENS[23:16], SENS[15:8], SENS[7:0], 8'h00, 8'h00, 8'h00, 8'h00});
  endtask

  task automatic scn_temp_and_full();
    measure(rmcd_pkg::CMD_RAW_T, 8'hff, 8'hff, 2, PRI, 1'b1);
    rd_check(4, '{stat(1'b0), TMP[23:16], TMP[15:8], TMP[7:0], 8'h00, 8'h00, 8'h00, 8'h00});
    measure(rmcd_pkg::CMD_FULL, 8'h00, 8'h00, 0, PRI, 1'b0);
    check("full kind", 16'(seen_full), 16'h0001);
    rd_check(8, '{stat(1'b0), SENS[23:16], SENS[15:8], SENS[7:0], TMP[23:16], TMP[15:8], TMP[7:0], 8'h00});
  endtask

  task automatic scn_select();
    select(rmcd_pkg::CMD_SEL_SEC, 1'b1);
    rd_check(5, '{stat(1'b1), SEC[15:8], SEC[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    measure(rmcd_pkg::CMD_RAW_S2, 8'h00, 8'h00, 0, SEC, 1'b0);
    measure(rmcd_pkg::CMD_RAW_T, 8'h01, 8'h02, 2, SEC, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("selection after mid reset", 16'(cfg_sel_secondary), 16'h0000);
    select(rmcd_pkg::CMD_SEL_SEC, 1'b1);
    select(rmcd_pkg::CMD_SEL_PRI, 1'b0);
    measure(rmcd_pkg::CMD_RAW_S0, 8'h00, 8'h00, 0, PRI, 1'b0);
  endtask

  task automatic scn_bad_addr();
    logic a;
    i_master.start_cond();
    i_master.write_byte({ADDR ^ 7'h01, 1'b0}, a);
    i_master.stop_cond();
    check("foreign addr ack", 16'(a), 16'h0000);
    check("sda_out level", 16'(sda_out), 16'h0000);
  endtask

  initial begin
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    scn_reset_state();
    scn_stored_and_inline();
    scn_refused();
    scn_temp_and_full();
    scn_select();
    scn_bad_addr();
    print_verdict();
  end
endmodule
`default_nettype wire
